// File: core/cedc_pkg.sv
package cedc_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_CTRL = 32'h4002_0000;
   localparam logic [31:0] ADDR_START = 32'h4002_0004;
   localparam logic [31:0] ADDR_SRC = 32'h4002_0008;
   localparam logic [31:0] ADDR_LEN = 32'h4002_000C;
   localparam logic [31:0] ADDR_DST = 32'h4002_0010;
   localparam logic [31:0] ADDR_STAT = 32'h4002_0014;
   // reset values
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_PTR = 32'h0000_0000;
   localparam logic [23:0] RST_LEN = 24'h00_0000;
   localparam logic [17:0] CTRL_MASK = 18'h3_FFFF;
   // control fields
   localparam int BIT_MORE = 16;
   localparam int BIT_HASH = 9;
   localparam int BIT_IRQEN = 8;
   localparam int MD_LSB = 2;
   localparam int ALG_LSB = 0;
   // status fields
   localparam int STB_IRQ = 2;
   localparam int STB_WAIT = 1;
   localparam int STB_IDLE = 0;
   localparam int LEN_W = 24;
   // block sizes in bytes
   localparam logic [7:0] BLK_AES = 8'h10;
   localparam logic [7:0] BLK_H32 = 8'h40;
   localparam logic [7:0] BLK_H64 = 8'h80;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;
   localparam int FIFO_DEPTH = 16;

   typedef enum logic [3:0] {
      ALG_NONE = 4'b0000, AES_ECB = 4'b0001, AES_CTR = 4'b0010, AES_CBC = 4'b0011,
      H_MD5 = 4'b0100, H_SHA1 = 4'b0101, H_SHA256_224 = 4'b0110, H_SHA256 = 4'b0111,
      H_SHA384 = 4'b1000, H_SHA512 = 4'b1001, H_SHA512_224 = 4'b1010,
      H_SHA512_256 = 4'b1011
   } cedc_alg_e;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_RUN = 2'b01, S_DRAIN = 2'b10, S_WAIT = 2'b11
   } cedc_state_e;

   typedef struct packed {
      logic req;
      logic [31:0] addr;
   } cedc_rd_s;

   typedef struct packed {
      logic req;
      logic [31:0] addr;
      logic [31:0] data;
   } cedc_wr_s;
endpackage

// File: core/cedc_engine.sv
`timescale 1ns/100ps

// word buffer between fetch and store sides
module cedc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // sync reset, active low
   input wire logic in_valid_i, // push request
   output logic in_ready_o, // room available
   input wire logic [WIDTH-1:0] in_data_i, // pushed word
   output logic out_valid_o, // word available
   input wire logic out_ready_i, // pop request
   output logic [WIDTH-1:0] out_data_o // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp, rp, next_wp, next_rp;
   logic push, pop;

   // pointers carry one extra bit so full and empty differ
   always_comb begin
      // flags first, so push and pop never see last pass's values
      in_ready_o = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
      out_valid_o = (wp != rp);
      out_data_o = mem[rp[AW-1:0]];
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      next_wp = push ? wp + 1'b1 : wp;
      next_rp = pop ? rp + 1'b1 : rp;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
      end
      if (push) begin
         mem[wp[AW-1:0]] <= in_data_i;
      end
   end
endmodule // cedc_fifo

module cedc_engine (
   input wire logic mclk_i, // 40 MHz system clock
   input wire logic reset_n_i, // sync reset, active low
   input wire logic [31:0] reg_addr_i, // register byte address
   input wire logic reg_wr_i, // register write strobe
   input wire logic reg_rd_i, // register read strobe
   input wire logic [31:0] reg_wdata_i, // write data
   output logic [31:0] reg_rdata_o, // read data, one cycle after strobe
   output cedc_pkg::cedc_rd_s mem_rd_o, // fetch request and address
   input wire logic mem_rd_ack_i, // fetch done, data valid
   input wire logic [31:0] mem_rd_data_i, // fetched word
   output cedc_pkg::cedc_wr_s mem_wr_o, // store request, address, data
   input wire logic mem_wr_ack_i, // store done
   output cedc_pkg::cedc_alg_e alg_o, // algorithm latched at start
   output logic irq_o // interrupt request line
);
   logic [17:0] ctrl, next_ctrl;
   logic [31:0] src, next_src, dst, next_dst, next_rdata;
   logic [23:0] len, next_len;
   logic [7:0] ofs, next_ofs;
   logic idle, next_idle, waitf, next_waitf, irq, next_irq;
   cedc_pkg::cedc_state_e st, next_st;
   cedc_pkg::cedc_rd_s next_rd;
   cedc_pkg::cedc_wr_s next_wr;
   cedc_pkg::cedc_alg_e alg, next_alg, dec;
   logic start, sw_own, f_in_valid, f_in_ready, f_out_valid, f_out_ready, more;
   logic [31:0] f_in_data, f_out_data;

   // maps mode and algorithm fields onto one code; ALG_NONE marks reserved
   function automatic cedc_pkg::cedc_alg_e dec_alg(input logic [17:0] c);
      logic [1:0] md;
      logic [1:0] al;
      md = c[cedc_pkg::MD_LSB +: 2];
      al = c[cedc_pkg::ALG_LSB +: 2];
      dec_alg = cedc_pkg::ALG_NONE;
      if (!c[cedc_pkg::BIT_HASH]) begin
         if (al == 2'b00) begin
            dec_alg = md[1] ? (md[0] ? cedc_pkg::AES_CBC : cedc_pkg::AES_CTR)
                            : cedc_pkg::AES_ECB;
         end
      end else if (md == 2'b00) begin
         dec_alg = cedc_pkg::cedc_alg_e'({2'b01, al});
      end else if (md == 2'b01) begin
         dec_alg = cedc_pkg::cedc_alg_e'({2'b10, al});
      end
   endfunction

   // padding granule for the latched algorithm
   function automatic logic [7:0] blk_bytes(input cedc_pkg::cedc_alg_e a);
      if (a >= cedc_pkg::H_SHA384) begin
         blk_bytes = cedc_pkg::BLK_H64;
      end else if (a >= cedc_pkg::H_MD5) begin
         blk_bytes = cedc_pkg::BLK_H32;
      end else begin
         blk_bytes = cedc_pkg::BLK_AES;
      end
   endfunction

   // bytes beyond the count in the last word are zeroed, little endian
   function automatic logic [31:0] mask_word(input logic [31:0] d, input logic [23:0] n);
      mask_word = d;
      if (n < 24'h00_0004) begin
         mask_word = d & ((32'h0000_0001 << {n[1:0], 3'b000}) - 32'h0000_0001);
      end
   endfunction

   cedc_fifo #(.WIDTH(32), .DEPTH(cedc_pkg::FIFO_DEPTH)) u_fifo (
      .clk_i(mclk_i),
      .rst_n_i(reset_n_i),
      .in_valid_i(f_in_valid),
      .in_ready_o(f_in_ready),
      .in_data_i(f_in_data),
      .out_valid_o(f_out_valid),
      .out_ready_i(f_out_ready),
      .out_data_o(f_out_data)
   );

   // sequencing, pointers, count and register access
   always_comb begin
      next_st = st;
      next_ctrl = ctrl;
      next_src = src;
      next_len = len;
      next_dst = dst;
      next_ofs = ofs;
      next_idle = idle;
      next_waitf = waitf;
      next_irq = irq;
      next_alg = alg;
      next_rd = mem_rd_o;
      next_wr = mem_wr_o;
      next_rdata = 32'h0000_0000;
      f_in_valid = 1'b0;
      f_in_data = 32'h0000_0000;
      f_out_ready = 1'b0;
      dec = dec_alg(ctrl);
      more = ctrl[cedc_pkg::BIT_MORE];
      sw_own = (st == cedc_pkg::S_IDLE) || (st == cedc_pkg::S_WAIT);
      start = reg_wr_i && (reg_addr_i == cedc_pkg::ADDR_START) && reg_wdata_i[0];
      // software owns the set-up registers only while the engine is parked
      if (reg_wr_i && sw_own) begin
         if (reg_addr_i == cedc_pkg::ADDR_CTRL) begin
            next_ctrl = reg_wdata_i[17:0] & cedc_pkg::CTRL_MASK;
         end else if (reg_addr_i == cedc_pkg::ADDR_SRC) begin
            next_src = reg_wdata_i;
         end else if (reg_addr_i == cedc_pkg::ADDR_LEN) begin
            next_len = reg_wdata_i[cedc_pkg::LEN_W-1:0];
         end else if (reg_addr_i == cedc_pkg::ADDR_DST) begin
            next_dst = reg_wdata_i;
         end
      end
      // read mux; start register and unmapped addresses read zero
      if (reg_rd_i) begin
         if (reg_addr_i == cedc_pkg::ADDR_CTRL) begin
            next_rdata = {14'h0000, ctrl};
         end else if (reg_addr_i == cedc_pkg::ADDR_SRC) begin
            next_rdata = src;
         end else if (reg_addr_i == cedc_pkg::ADDR_LEN) begin
            next_rdata = {8'h00, len};
         end else if (reg_addr_i == cedc_pkg::ADDR_DST) begin
            next_rdata = dst;
         end else if (reg_addr_i == cedc_pkg::ADDR_STAT) begin
            next_rdata = {29'h0000_0000, irq, waitf, idle};
         end
      end
      case (st)
         cedc_pkg::S_IDLE: begin
            // reserved algorithm codes refuse the start
            if (start && dec != cedc_pkg::ALG_NONE) begin
               next_st = cedc_pkg::S_RUN;
               next_idle = 1'b0;
               next_irq = 1'b0;
               next_alg = dec;
               next_ofs = 8'h00;
            end
         end
         cedc_pkg::S_WAIT: begin
            if (start) begin
               next_st = cedc_pkg::S_RUN;
               next_waitf = 1'b0;
            end
         end
         cedc_pkg::S_RUN: begin
            // one fetch outstanding; room was checked when it was issued
            if (mem_rd_o.req) begin
               if (mem_rd_ack_i) begin
                  next_rd.req = 1'b0;
                  f_in_valid = 1'b1;
                  f_in_data = mask_word(mem_rd_data_i, len);
                  next_src = src + cedc_pkg::WORD_STEP;
                  next_len = (len < 24'h00_0004) ? 24'h00_0000 : len - 24'h00_0004;
                  next_ofs = (ofs + 8'h04) & (blk_bytes(alg) - 8'h01);
               end
            end else if (len != 24'h00_0000) begin
               if (f_in_ready) begin
                  next_rd.req = 1'b1;
                  next_rd.addr = src;
               end
            end else if (!more && ofs != 8'h00) begin
               f_in_valid = 1'b1;
               if (f_in_ready) begin
                  next_ofs = (ofs + 8'h04) & (blk_bytes(alg) - 8'h01);
               end
            end else begin
               next_st = cedc_pkg::S_DRAIN;
            end
         end
         default: begin
            // finish only once every word has reached memory
            if (!f_out_valid && !mem_wr_o.req) begin
               if (more) begin
                  next_st = cedc_pkg::S_WAIT;
                  next_waitf = 1'b1;
               end else begin
                  next_st = cedc_pkg::S_IDLE;
                  next_idle = 1'b1;
                  next_irq = ctrl[cedc_pkg::BIT_IRQEN];
               end
            end
         end
      endcase
      // store side drains the buffer one word per acknowledged write
      if (mem_wr_o.req) begin
         if (mem_wr_ack_i) begin
            next_wr.req = 1'b0;
            next_dst = dst + cedc_pkg::WORD_STEP;
         end
      end else if (f_out_valid) begin
         f_out_ready = 1'b1;
         next_wr.req = 1'b1;
         next_wr.addr = dst;
         next_wr.data = f_out_data;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         st <= cedc_pkg::S_IDLE;
         ctrl <= cedc_pkg::RST_CTRL[17:0];
         src <= cedc_pkg::RST_PTR;
         len <= cedc_pkg::RST_LEN;
         dst <= cedc_pkg::RST_PTR;
         ofs <= 8'h00;
         idle <= 1'b1;
         waitf <= 1'b0;
         irq <= 1'b0;
         alg <= cedc_pkg::ALG_NONE;
         mem_rd_o <= '0;
         mem_wr_o <= '0;
         reg_rdata_o <= 32'h0000_0000;
         irq_o <= 1'b0;
         alg_o <= cedc_pkg::ALG_NONE;
      end else begin
         st <= next_st;
         ctrl <= next_ctrl;
         src <= next_src;
         len <= next_len;
         dst <= next_dst;
         ofs <= next_ofs;
         idle <= next_idle;
         waitf <= next_waitf;
         irq <= next_irq;
         alg <= next_alg;
         mem_rd_o <= next_rd;
         mem_wr_o <= next_wr;
         reg_rdata_o <= next_rdata;
         irq_o <= next_irq;
         alg_o <= next_alg;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);

   ctr_decode_a: assert property (!ctrl[9] && ctrl[3:0] == 4'b1000 |-> dec == cedc_pkg::AES_CTR)
      else $error("counter mode decode wrong");
   res_refuse_a: assert property (st == cedc_pkg::S_IDLE && start && !ctrl[9] && ctrl[1:0] != 2'b00
      |=> st == cedc_pkg::S_IDLE && idle)
      else $error("reserved cipher code started");
   start_busy_a: assert property (st == cedc_pkg::S_IDLE && start && dec != cedc_pkg::ALG_NONE
      |=> !idle ##0 st == cedc_pkg::S_RUN)
      else $error("start did not begin work");
   src_step_a: assert property (mem_rd_o.req && mem_rd_ack_i && st == cedc_pkg::S_RUN
      |=> src == $past(src) + 32'h0000_0004)
      else $error("source pointer not advanced");
   dst_step_a: assert property (mem_wr_o.req && mem_wr_ack_i
      |=> dst == $past(dst) + 32'h0000_0004)
      else $error("destination pointer not advanced");
   pad_zero_a: assert property (f_in_valid && !mem_rd_o.req |-> f_in_data == 32'h0000_0000)
      else $error("padding word not zero");
   stat_irq_a: assert property (reg_rd_i && reg_addr_i == cedc_pkg::ADDR_STAT
      |=> reg_rdata_o[2] == $past(irq_o) && reg_rdata_o[0] == $past(idle))
      else $error("status does not mirror request line");
   frag_wait_a: assert property (st == cedc_pkg::S_WAIT |-> waitf && !idle)
      else $error("awaiting input with idle set");
   resume_a: assert property (st == cedc_pkg::S_WAIT && start |=> !waitf ##1 st != cedc_pkg::S_IDLE)
      else $error("resume did not clear wait");
   irq_gate_a: assert property (!ctrl[8] && st == cedc_pkg::S_DRAIN |=> !irq_o)
      else $error("interrupt raised while disabled");
endmodule // cedc_engine

// File: verif/cedc_mem_model.sv
`timescale 1ns/100ps
// memory behind the fetch and store ports; answer delay set by the bench
module cedc_mem_model (
   input wire logic mclk_i, // clock
   input wire logic reset_n_i, // sync reset, active low
   input wire logic slow_rd_i, // stretch fetch answers
   input wire logic slow_wr_i, // stretch store answers
   input cedc_pkg::cedc_rd_s rd_i, // fetch request
   output logic rd_ack_o = 1'b0, // fetch done
   output logic [31:0] rd_data_o = 32'h0000_0000, // fetched word
   input cedc_pkg::cedc_wr_s wr_i, // store request
   output logic wr_ack_o = 1'b0 // store done
);
   logic [1:0] rd_cnt;
   logic [1:0] wr_cnt;
   // content is a fixed function of the address so the bench can predict it
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {a[15:0] ^ 16'hC3A5, ~a[15:0]};
   endfunction
   // data line toggles when idle so a stale word never passes for a fresh one
   always @(posedge mclk_i) begin
      rd_ack_o <= 1'b0;
      wr_ack_o <= 1'b0;
      rd_data_o <= ~rd_data_o;
      if (!reset_n_i) begin
         rd_cnt <= 2'h0;
         wr_cnt <= 2'h0;
      end else begin
         if (rd_i.req && !rd_ack_o) begin
            rd_cnt <= rd_cnt + 2'h1;
            if (rd_cnt == {2{slow_rd_i}}) begin
               rd_ack_o <= 1'b1;
               rd_data_o <= word_at(rd_i.addr);
               rd_cnt <= 2'h0;
            end
         end
         if (wr_i.req && !wr_ack_o) begin
            wr_cnt <= wr_cnt + 2'h1;
            if (wr_cnt == {2{slow_wr_i}}) begin
               wr_ack_o <= 1'b1;
               wr_cnt <= 2'h0;
            end
         end
      end
   end
endmodule // cedc_mem_model

// File: verif/crypto_engine_dma_control_tb_top.sv
`timescale 1ns/100ps
module crypto_engine_dma_control_tb_top;
   logic mclk_i, reset_n_i, reg_wr_i, reg_rd_i, rd_chk, pend, slow_rd, slow_wr;
   logic mem_rd_ack_i, mem_wr_ack_i, irq_o;
   logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o, mem_rd_data_i, v, c;
   logic [1:0] md, al;
   logic [15:0] lf;
   cedc_pkg::cedc_rd_s mem_rd_o;
   cedc_pkg::cedc_wr_s mem_wr_o;
   cedc_pkg::cedc_alg_e alg_o;
   logic [31:0] rd_q[$];
   logic [63:0] st_q[$];
   int errors, compares, tot_b, done_w, i;

   cedc_engine cedc_engine_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .mem_rd_o(mem_rd_o), .mem_rd_ack_i(mem_rd_ack_i),
      .mem_rd_data_i(mem_rd_data_i), .mem_wr_o(mem_wr_o), .mem_wr_ack_i(mem_wr_ack_i),
      .alg_o(alg_o), .irq_o(irq_o));
   cedc_mem_model cedc_mem_model_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .slow_rd_i(slow_rd),
      .slow_wr_i(slow_wr), .rd_i(mem_rd_o), .rd_ack_o(mem_rd_ack_i), .rd_data_o(mem_rd_data_i),
      .wr_i(mem_wr_o), .wr_ack_o(mem_wr_ack_i));

   // 40 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end

   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_st(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      if (errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // watcher: oldest note against each checked read answer and each accepted store
   always @(posedge mclk_i) begin
      if (pend) check_val(reg_rdata_o, rd_q.size() ? rd_q.pop_front() : 32'hx);
      if (mem_wr_o.req && mem_wr_ack_i)
         check_st({mem_wr_o.addr, mem_wr_o.data}, st_q.size() ? st_q.pop_front() : 64'hx);
      pend <= reg_rd_i && rd_chk;
   end

   // same address-to-word map as the memory model, kept local to the bench
   function automatic logic [31:0] word_at(input logic [31:0] a);
      return {a[15:0] ^ 16'hC3A5, ~a[15:0]};
   endfunction

   function automatic logic [15:0] lfsr_step(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask

   // checked reads leave a note; unchecked ones only fill v for polling
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic chk);
      if (chk) rd_q.push_back(e);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      rd_chk <= chk;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask

   // one fragment: program, note expected stores, start, wait, check pointers
   task automatic frag(input logic [31:0] ctl, input int n, input int blk, input logic [31:0] ea);
      logic [31:0] s, d, m;
      int nw, tw, k;
      lf = lfsr_step(lf);
      s = {14'h0800, lf, 2'b00};
      lf = lfsr_step(lf);
      d = {14'h0C00, lf, 2'b00};
      slow_rd <= lf[0];
      slow_wr <= lf[1];
      wr(cedc_pkg::ADDR_SRC, s);
      wr(cedc_pkg::ADDR_LEN, 32'(n));
      wr(cedc_pkg::ADDR_DST, d);
      wr(cedc_pkg::ADDR_CTRL, ctl);
      nw = (n + 3) / 4;
      tot_b += n;
      tw = ctl[16] ? nw : (tot_b + blk - 1) / blk * blk / 4 - done_w;
      for (k = 0; k < tw; k++) begin
         m = (n - 4 * k >= 4) ? 32'hFFFF_FFFF : (32'h1 << (8 * (n - 4 * k))) - 32'h1;
         if (k >= nw) m = 32'h0000_0000;
         st_q.push_back({d + 32'(4 * k), word_at(s + 32'(4 * k)) & m});
      end
      done_w = ctl[16] ? done_w + nw : 0;
      if (!ctl[16]) tot_b = 0;
      wr(cedc_pkg::ADDR_START, 32'h0000_0001);
      v = 32'h0000_0000;
      for (k = 0; k < 3000 && !(v[1] | v[0]); k++) rd(cedc_pkg::ADDR_STAT, 32'h0, 1'b0);
      if (k >= 3000) begin
         errors++;
         stop_test();
      end
      check_val(32'(alg_o), ea);
      check_val(32'(irq_o), ctl[16] ? 32'h0 : 32'(ctl[8]));
      rd(cedc_pkg::ADDR_STAT, ctl[16] ? 32'h2 : {29'h0, ctl[8], 2'b01}, 1'b1);
      rd(cedc_pkg::ADDR_SRC, s + 32'(4 * nw), 1'b1);
      rd(cedc_pkg::ADDR_LEN, 32'h0000_0000, 1'b1);
      rd(cedc_pkg::ADDR_DST, d + 32'(4 * tw), 1'b1);
   endtask

   // main sequence
   initial begin
      {reset_n_i, reg_wr_i, reg_rd_i, rd_chk, slow_rd, slow_wr} = 6'h00;
      reg_addr_i = 32'h0000_0000;
      reg_wdata_i = 32'h0000_0000;
      lf = 16'h5564;
      {errors, compares, tot_b, done_w} = {32'd0, 32'd0, 32'd0, 32'd0};
      repeat (20) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      // reset values, the write-only start and an unmapped place
      for (i = 0; i < 7; i++) rd(32'h4002_0000 + 32'(4 * i), 32'(i == 5), 1'b1);
      wr(cedc_pkg::ADDR_LEN, 32'hFFFF_FFFF);
      rd(cedc_pkg::ADDR_LEN, 32'h00FF_FFFF, 1'b1);
      // reserved cipher algorithm and reserved hash family must not start
      wr(cedc_pkg::ADDR_CTRL, 32'h0000_0001);
      wr(cedc_pkg::ADDR_START, 32'h0000_0001);
      rd(cedc_pkg::ADDR_STAT, 32'h0000_0001, 1'b1);
      wr(cedc_pkg::ADDR_CTRL, 32'h0000_0208);
      wr(cedc_pkg::ADDR_START, 32'h0000_0001);
      rd(cedc_pkg::ADDR_STAT, 32'h0000_0001, 1'b1);
      check_val(32'(alg_o), 32'h0000_0000);
      // every cipher mode and every hash code, interrupt enable alternating
      for (i = 0; i < 12; i++) begin
         lf = lfsr_step(lf);
         md = i < 4 ? i[1:0] : {1'b0, i >= 8};
         al = i < 4 ? 2'h0 : i[1:0];
         c = {22'h0, i >= 4, i[0], 4'h0, md, al};
         frag(c, 1 + lf[5:0], i < 4 ? 16 : (i < 8 ? 64 : 128), i == 0 ? 1 : i);
      end
      // two fragments: awaiting input, then resume and finish with padding
      frag(32'h0001_0100 | 32'h0000_0200, 64, 64, 4);
      frag(32'h0000_0300, 10, 64, 4);
      repeat (5) @(posedge mclk_i);
      check_val(32'(st_q.size()), 32'h0000_0000);
      stop_test();
   end
endmodule // crypto_engine_dma_control_tb_top
